// ---- hdl/smc_defines.svh ----
// timing counts and encodings for the system mode controller
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH
`define SMC_CLK_HZ 40000000
`define SMC_RESET_DELAY_US 10
`define SMC_RESET_DELAY_CYC ((`SMC_RESET_DELAY_US * (`SMC_CLK_HZ / 1000000)))
`define SMC_LONG_WINDOW_MS 200
`define SMC_LONG_WINDOW_CYC ((`SMC_LONG_WINDOW_MS * (`SMC_CLK_HZ / 1000)))
`define SMC_SPI_BITS 16
`define SMC_MODE_MSB 15
`define SMC_MODE_LSB 14
`define SMC_WR_BIT 13
`define SMC_REQ_NORMAL 2'h0
`define SMC_REQ_STOP 2'h1
`define SMC_REQ_SLEEP 2'h2
`define SMC_REQ_RESET 2'h3
`endif

// ---- hdl/smc_pkg.sv ----
// types of the system mode controller
package smc_pkg;
	typedef enum logic [2:0] {
		SMC_INIT,
		SMC_NORMAL,
		SMC_STOP,
		SMC_SLEEP,
		SMC_RESTART,
		SMC_FAILSAFE
	} smc_mode_t;
	typedef struct packed {
		logic watchdog_fail;
		logic vcc_undervoltage;
		logic overtemp;
	} smc_fault_t;
	typedef struct packed {
		logic can_wake;
		logic pin_wake;
	} smc_wake_t;
endpackage

// ---- hdl/smc_mode_ctrl.sv ----
// operating-mode state machine with spi slave and power-on strap latching
// What this block does
// - six modes, normal is the main one
// - init entered at power-up and soft reset
// - stop keeps main regulator on
// - sleep turns main regulator off
// - wake or failure enters restart, resets host
// - fault gone, reset delay, then normal
// - overheating enters fail-safe, regulator off; watchdog and overvoltage failures do too with interrupt strap low
// - fail-safe left only by wake or cool-down
// - development mode halts the watchdog counter
// - strap low during init selects development
// - interrupt-pin strap stores failure behaviour
// - sixteen-bit spi, host master, device slave
// - host writes mode field to request modes
// - mode field cleared passing through restart
// - start in init after power-on threshold
// - init starts watchdog with long window
// - any spi command in init gives normal
// - no trigger in long window gives restart
// - wake events in init are discarded
// - wake in normal raises interrupt only
`timescale 1ns/100ps
`include "smc_defines.svh"
module smc_mode_ctrl #(
	// reset delay and long open window, both in clock cycles
	parameter int RESET_DELAY_CYC = `SMC_RESET_DELAY_CYC,
	parameter int LONG_WINDOW_CYC = `SMC_LONG_WINDOW_CYC
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic soft_reset,
	// spi link from the host
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	// watchdog and supply supervision
	input wire logic wd_trigger,
	input wire logic wd_fail_ext,
	input wire logic vcc_ov,
	input wire smc_pkg::smc_fault_t fault_in,
	input wire smc_pkg::smc_wake_t wake_in,
	// board straps read during init
	input wire logic fail_out_three,
	input wire logic int_strap,
	// supply, host reset and status outputs
	output logic main_regulator_output,
	output logic reset_output_pin_n,
	output logic wake_irq,
	output logic dev_mode,
	output logic cfg_restart_on_fail,
	output smc_pkg::smc_mode_t mode
);
	// two-stage synchronisers for the spi, trigger, wake and strap pins
	// bit order: sck, cs active high, mosi, trigger, can wake, pin wake,
	// development strap, interrupt strap; only the second stage is read
	logic [7:0] s1_q;
	logic [7:0] s2_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1_q <= 8'h00;
			s2_q <= 8'h00;
		end else begin
			s1_q <= {spi_sck, ~spi_cs_n, spi_mosi, wd_trigger, wake_in, fail_out_three, int_strap};
			s2_q <= s1_q;
		end
	end
	// synchronised views of each pin
	wire sck_s = s2_q[7];
	wire cs_s = s2_q[6];
	wire mosi_s = s2_q[5];
	wire trig_s = s2_q[4];
	wire wake_s = |s2_q[3:2];
	wire strap_dev_s = s2_q[1]; // low selects development mode
	wire int_s = s2_q[0];

	// edge detection on synchronised clock and trigger
	// delay registers reset to the idle levels of sck, cs and trigger,
	// so no false edge follows reset
	logic sck_d1_q;
	logic cs_d1_q;
	logic trig_d1_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sck_d1_q <= 1'b0;
			cs_d1_q <= 1'b0;
			trig_d1_q <= 1'b0;
		end else begin
			sck_d1_q <= sck_s;
			cs_d1_q <= cs_s;
			trig_d1_q <= trig_s;
		end
	end
	wire sck_rise = sck_s & ~sck_d1_q;
	wire sck_fall = ~sck_s & sck_d1_q;
	wire cs_end = ~cs_s & cs_d1_q;
	wire trig_rise = trig_s & ~trig_d1_q;

	// spi shift register, 16 bits msb first, mode 0
	// mosi is taken on each synchronised sck rise
	// the bit count is cleared while cs is idle
	logic [15:0] sh_q;
	logic [4:0] cnt_q;
	logic [15:0] tx_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sh_q <= 16'h0000;
			cnt_q <= 5'h00;
		end else if (!cs_s) begin
			cnt_q <= 5'h00;
		end else if (sck_rise) begin
			sh_q <= {sh_q[14:0], mosi_s};
			cnt_q <= cnt_q + 5'h01;
		end
	end
	// frame complete only with exactly sixteen clocks
	// any frame with at least one clock counts as a command in init
	wire frame_ok = cs_end & (cnt_q == 5'(`SMC_SPI_BITS));
	wire any_cmd = cs_end & (cnt_q != 5'h00);
	wire wr_mode = frame_ok & sh_q[`SMC_WR_BIT];
	wire [1:0] req = sh_q[`SMC_MODE_MSB:`SMC_MODE_LSB];

	// strap latching while in init, stored when the first init ends
	// straps follow the pins during the first init and freeze after it
	logic dev_q;
	logic cfgp_q;
	logic cfg_done_q;

	// mode state and timers
	// one timer serves the long window, the reset delay and fail-safe
	smc_pkg::smc_mode_t st_q;
	smc_pkg::smc_mode_t st_d;
	logic [31:0] tmr_q;
	logic [1:0] field_q;
	logic wd_fail_cnt_q; // sticky: a watchdog failure has happened
	logic irq_q; // wake interrupt register

	// named decodes of the current mode, shared below
	wire in_init = (st_q == smc_pkg::SMC_INIT);
	wire in_normal = (st_q == smc_pkg::SMC_NORMAL);
	wire in_restart = (st_q == smc_pkg::SMC_RESTART);
	// soft reset overrides the decoded next mode, so outputs follow it too
	smc_pkg::smc_mode_t st_next;
	assign st_next = soft_reset ? smc_pkg::SMC_INIT : st_d;

	// regulator stays on except in the two modes that cut it
	function automatic logic reg_on_for(input smc_pkg::smc_mode_t m);
		logic on;
		on = 1'b1;
		case (m)
			smc_pkg::SMC_SLEEP: on = 1'b0;
			smc_pkg::SMC_FAILSAFE: on = 1'b0;
			smc_pkg::SMC_STOP: on = 1'b1;
			default: on = 1'b1;
		endcase
		return on;
	endfunction

	// host reset released in every mode but restart
	function automatic logic rst_release_for(input smc_pkg::smc_mode_t m);
		return m != smc_pkg::SMC_RESTART;
	endfunction

	// mode asked for by a written mode field
	function automatic smc_pkg::smc_mode_t req_mode(input logic [1:0] r);
		smc_pkg::smc_mode_t m;
		m = smc_pkg::SMC_NORMAL;
		case (r)
			`SMC_REQ_STOP: m = smc_pkg::SMC_STOP;
			`SMC_REQ_SLEEP: m = smc_pkg::SMC_SLEEP;
			`SMC_REQ_RESET: m = smc_pkg::SMC_INIT;
			default: m = smc_pkg::SMC_NORMAL;
		endcase
		return m;
	endfunction

	// long open window runs only in init, halted in development mode
	// a rising trigger restarts it; expiry is a watchdog failure
	wire wd_run = in_init & ~dev_q;
	wire wd_expire = wd_run & (tmr_q >= 32'(LONG_WINDOW_CYC));
	// external and internal failure sources, masked in development mode
	wire wd_src = wd_fail_ext | fault_in.watchdog_fail;
	wire wd_fail = wd_expire | (wd_src & ~dev_q);
	// overvoltage here always has its reset enabled
	// any of these ends normal or stop operation
	wire critical = fault_in.vcc_undervoltage | fault_in.overtemp | wd_fail | vcc_ov;
	// interrupt-pin strap low sends watchdog and overvoltage failures to fail-safe, high to restart; overheating always to fail-safe
	wire to_failsafe = ((wd_fail | vcc_ov) & ~cfgp_q) | fault_in.overtemp;
	// conditions that keep restart from ending in normal
	wire fault_now = fault_in.vcc_undervoltage | fault_in.overtemp;

	// next-mode decode
	// failures win over host requests; wakes count in sleep and fail-safe
	always_comb begin
		st_d = st_q;
		case (st_q)
			smc_pkg::SMC_INIT: begin
				// wake ignored here, it is lost
				// a failure of the long window comes first
				if (wd_fail)
					st_d = smc_pkg::SMC_RESTART;
				else if (any_cmd)
					st_d = smc_pkg::SMC_NORMAL;
			end
			smc_pkg::SMC_NORMAL, smc_pkg::SMC_STOP: begin
				// stop differs from normal only in raising no wake interrupt
				if (critical)
					st_d = to_failsafe ? smc_pkg::SMC_FAILSAFE : smc_pkg::SMC_RESTART;
				else if (wr_mode)
					st_d = req_mode(req);
			end
			smc_pkg::SMC_SLEEP: begin
				// only a wake or overheating leaves sleep
				if (fault_in.overtemp)
					st_d = smc_pkg::SMC_FAILSAFE;
				else if (wake_s)
					st_d = smc_pkg::SMC_RESTART;
			end
			smc_pkg::SMC_RESTART: begin
				// host held in reset until the delay runs out fault-free
				if (!fault_now && tmr_q >= 32'(RESET_DELAY_CYC))
					st_d = smc_pkg::SMC_NORMAL;
				else if (fault_in.overtemp)
					st_d = smc_pkg::SMC_FAILSAFE;
			end
			smc_pkg::SMC_FAILSAFE: begin
				// permanent until wake or cooled down
				if (wake_s | ~fault_in.overtemp & ~fault_in.vcc_undervoltage & tmr_q != 0)
					st_d = smc_pkg::SMC_RESTART;
			end
			// unused codes fall back to init
			default: st_d = smc_pkg::SMC_INIT;
		endcase
	end

	// mode register, init after power-on or soft reset
	// soft reset is a level: init is forced for every cycle it is held
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			st_q <= smc_pkg::SMC_INIT;
		else if (soft_reset)
			st_q <= smc_pkg::SMC_INIT;
		else
			st_q <= st_d;
	end

	// shared timer, restarts on every mode change
	// saturates at its top and stands in init while development holds it
	// a trigger edge restarts the long window
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			tmr_q <= 32'h0000_0000;
		else if (st_next != st_q || (trig_rise && wd_run))
			tmr_q <= 32'h0000_0000;
		else if (tmr_q != 32'hFFFF_FFFF && !(st_q == smc_pkg::SMC_INIT && dev_q))
			tmr_q <= tmr_q + 32'h0000_0001;
	end

	// mode field as read back, cleared through restart
	// writes in init only leave init, so they are not stored
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			field_q <= `SMC_REQ_NORMAL;
		else if (in_restart)
			field_q <= `SMC_REQ_NORMAL;
		else if (wr_mode && st_q != smc_pkg::SMC_INIT)
			field_q <= req;
	end

	// strap capture during init, stored when the first init ends
	// the first command or a watchdog failure ends the capture for good
	// the first two captures read the synchronisers' reset zeros, so dev_q is high until the pins arrive
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dev_q <= 1'b0;
			cfgp_q <= 1'b0;
			cfg_done_q <= 1'b0;
			wd_fail_cnt_q <= 1'b0;
		end else begin
			if (st_q == smc_pkg::SMC_INIT && !cfg_done_q) begin
				dev_q <= ~strap_dev_s;
				cfgp_q <= int_s;
				cfg_done_q <= any_cmd | wd_fail;
			end
			if (wd_fail)
				wd_fail_cnt_q <= 1'b1;
		end
	end

	// wake interrupt in normal only, mode unchanged
	// level follows the synchronised wake while in normal
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			irq_q <= 1'b0;
		else
			irq_q <= in_normal & wake_s;
	end

	// restart cause, kept until the next entry into restart
	// bit 2 wake, bit 1 watchdog, bit 0 supply or overvoltage
	// read back in the low byte of every answer word
	logic [2:0] cause_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cause_q <= 3'h0;
		end else if (st_next == smc_pkg::SMC_RESTART && !in_restart) begin
			cause_q <= {wake_s, wd_fail, critical & ~wd_fail};
		end
	end

	// miso shift: current mode field then state
	// word loaded as cs goes active, shifted on each sck fall
	// layout: field, mode, development, strap, watchdog failed, cause
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			tx_q <= 16'h0000;
		else if (cs_s && !cs_d1_q)
			tx_q <= {field_q, 3'(st_q), dev_q, cfgp_q, wd_fail_cnt_q, cause_q, 5'h00};
		else if (cs_s && sck_fall)
			tx_q <= {tx_q[14:0], 1'b0};
	end

	// registered outputs
	// taken from the next mode so they change on the same edge as mode
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			main_regulator_output <= 1'b0;
			reset_output_pin_n <= 1'b0;
		end else begin
			main_regulator_output <= reg_on_for(st_next);
			reset_output_pin_n <= rst_release_for(st_next);
		end
	end

	// all outputs come straight from registers
	assign spi_miso = tx_q[15];
	assign wake_irq = irq_q;
	assign dev_mode = dev_q;
	assign cfg_restart_on_fail = cfgp_q;
	assign mode = st_q;
endmodule

// ---- bench/smc_mode_ctrl_asserts.sv ----
// checker watching the mode controller ports
`timescale 1ns/100ps
module smc_mode_ctrl_asserts (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic soft_reset,
	input wire logic main_regulator_output,
	input wire logic reset_output_pin_n,
	input wire logic wake_irq,
	input wire smc_pkg::smc_mode_t mode
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	// restart seen, then left on the next edge
	sequence s_restart_left;
		mode == smc_pkg::SMC_RESTART ##1 mode != smc_pkg::SMC_RESTART;
	endsequence
	a_mode_in_range: assert property (mode <= smc_pkg::SMC_FAILSAFE)
		else $error("mode outside the six modes");
	a_stop_reg_on: assert property (mode == smc_pkg::SMC_STOP |-> main_regulator_output)
		else $error("regulator off in stop");
	a_sleep_reg_off: assert property (mode == smc_pkg::SMC_SLEEP |-> !main_regulator_output)
		else $error("regulator on in sleep");
	a_failsafe_reg_off: assert property (mode == smc_pkg::SMC_FAILSAFE |-> !main_regulator_output)
		else $error("regulator on in fail-safe");
	a_restart_rst_low: assert property (mode == smc_pkg::SMC_RESTART |-> !reset_output_pin_n)
		else $error("reset released in restart");
	a_restart_to_normal: assert property (s_restart_left |->
		(mode == smc_pkg::SMC_NORMAL && reset_output_pin_n) || $past(soft_reset))
		else $error("restart not left to normal");
	a_restart_min_hold: assert property ($rose(mode == smc_pkg::SMC_RESTART) |->
		(mode == smc_pkg::SMC_RESTART) [*8])
		else $error("restart too short");
	a_soft_to_init: assert property (soft_reset |=> mode == smc_pkg::SMC_INIT)
		else $error("soft reset missed init");
	a_init_no_irq: assert property (mode == smc_pkg::SMC_INIT && $past(mode) == smc_pkg::SMC_INIT
		|-> !wake_irq)
		else $error("wake interrupt in init");
endmodule
bind smc_mode_ctrl smc_mode_ctrl_asserts i_chk (.clk_sys, .nrst, .soft_reset,
	.main_regulator_output, .reset_output_pin_n, .wake_irq, .mode);

// ---- bench/smc_host_model.sv ----
// host side spi master, sck idle low outside frames
`timescale 1ns/100ps
module smc_host_model (
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso
);
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// one whole frame, msb first, miso taken at each rise
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		spi_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi = w[i];
			#100 spi_sck = 1'b1;
			r[i] = spi_miso;
			#100 spi_sck = 1'b0;
		end
		#100 spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi; // released line shows no stale bit
		#200;
	endtask
endmodule

// ---- bench/tb_smc_mode_ctrl.sv ----
// testbench for the system mode controller
`timescale 1ns/100ps
module tb_smc_mode_ctrl;
	localparam int RD = 40;
	localparam int LW = 200;
	logic clk_sys, nrst, soft_reset, wd_fail_ext, spi_sck, spi_cs_n, spi_mosi, spi_miso;
	logic main_regulator_output, reset_output_pin_n, wake_irq, dev_mode, cfg_restart_on_fail;
	smc_pkg::smc_fault_t fault_in;
	smc_pkg::smc_wake_t wake_in;
	smc_pkg::smc_mode_t mode;
	logic wd_trigger, vcc_ov, fail_out_three, int_strap;
	logic [15:0] rx;
	int errors = 0;
	int n_checks = 0;
	smc_mode_ctrl #(.RESET_DELAY_CYC(RD), .LONG_WINDOW_CYC(LW)) i_dut (.clk_sys, .nrst,
		.soft_reset, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso, .wd_trigger,
		.wd_fail_ext, .vcc_ov, .fault_in, .wake_in, .fail_out_three,
		.int_strap, .main_regulator_output, .reset_output_pin_n, .wake_irq,
		.dev_mode, .cfg_restart_on_fail, .mode);
	smc_host_model i_host (.spi_sck, .spi_cs_n, .spi_mosi, .spi_miso);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	// edges, then settle so drives land 2 ns after the edge
	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			#2;
		end
	endtask
	// bounded wait for a mode
	task automatic wait_mode(input smc_pkg::smc_mode_t m, input int n);
		for (int i = 0; i < n && mode !== m; i++) cyc(1);
		chk(mode === m, "mode not reached");
		if (mode !== m) test_done();
	endtask
	task automatic send(input logic [1:0] req);
		i_host.xfer({req, 1'b1, 13'h0000}, rx);
	endtask
	task automatic t_power();
		cyc(3);
		chk(mode === smc_pkg::SMC_INIT && reset_output_pin_n === 1'b1, "no init");
		wake_in = 2'b11;
		cyc(6);
		chk(mode === smc_pkg::SMC_INIT, "wake left init");
		wake_in = 2'b00;
		send(2'h1);
		wait_mode(smc_pkg::SMC_NORMAL, 12);
		chk(dev_mode === 1'b0, "dev strap");
		chk(cfg_restart_on_fail === 1'b1, "cfg strap");
		$display("test power done");
	endtask
	task automatic t_modes();
		send(2'h1);
		wait_mode(smc_pkg::SMC_STOP, 12);
		chk(main_regulator_output === 1'b1, "regulator off in stop");
		send(2'h2);
		wait_mode(smc_pkg::SMC_SLEEP, 12);
		chk(main_regulator_output === 1'b0, "regulator on in sleep");
		wake_in.pin_wake = 1'b1;
		wait_mode(smc_pkg::SMC_RESTART, 10);
		chk(reset_output_pin_n === 1'b0, "host not in reset");
		wake_in.pin_wake = 1'b0;
		cyc(RD - 10);
		chk(mode === smc_pkg::SMC_RESTART, "restart too short");
		wait_mode(smc_pkg::SMC_NORMAL, 40);
		send(2'h0);
		chk(rx[15:11] === {2'h0, smc_pkg::SMC_NORMAL}, "field not cleared");
		chk(rx[7:5] === 3'h4, "restart cause not wake");
		$display("test modes done");
	endtask
	task automatic t_faults();
		wake_in.can_wake = 1'b1;
		cyc(6);
		chk(wake_irq === 1'b1 && mode === smc_pkg::SMC_NORMAL, "normal wake");
		wake_in.can_wake = 1'b0;
		fault_in.overtemp = 1'b1;
		wait_mode(smc_pkg::SMC_FAILSAFE, 10);
		cyc(8);
		chk(mode === smc_pkg::SMC_FAILSAFE, "fail-safe left");
		fault_in.overtemp = 1'b0;
		wait_mode(smc_pkg::SMC_RESTART, 10);
		wait_mode(smc_pkg::SMC_NORMAL, RD + 20);
		wd_fail_ext = 1'b1;
		wait_mode(smc_pkg::SMC_RESTART, 10);
		wd_fail_ext = 1'b0;
		wait_mode(smc_pkg::SMC_NORMAL, RD + 20);
		vcc_ov = 1'b1;
		wait_mode(smc_pkg::SMC_RESTART, 4);
		vcc_ov = 1'b0;
		wait_mode(smc_pkg::SMC_NORMAL, RD + 20);
		$display("test faults done");
	endtask
	task automatic t_window();
		soft_reset = 1'b1;
		cyc(1);
		soft_reset = 1'b0;
		wait_mode(smc_pkg::SMC_INIT, 3);
		cyc(LW - 50);
		wd_trigger = 1'b1;
		cyc(4);
		wd_trigger = 1'b0;
		cyc(100);
		chk(mode === smc_pkg::SMC_INIT, "trigger did not restart window");
		wait_mode(smc_pkg::SMC_RESTART, LW + 20);
		wait_mode(smc_pkg::SMC_NORMAL, RD + 20);
		$display("test window done");
	endtask
	// second power-up with both straps low
	task automatic t_dev();
		fail_out_three = 1'b0;
		int_strap = 1'b0;
		nrst = 1'b0;
		cyc(2);
		nrst = 1'b1;
		cyc(3);
		chk(mode === smc_pkg::SMC_INIT && dev_mode === 1'b1, "dev strap");
		cyc(LW + 20);
		chk(mode === smc_pkg::SMC_INIT, "watchdog ran in development");
		send(2'h0);
		wait_mode(smc_pkg::SMC_NORMAL, 12);
		chk(cfg_restart_on_fail === 1'b0, "cfg strap low");
		wd_fail_ext = 1'b1;
		cyc(6);
		chk(mode === smc_pkg::SMC_NORMAL, "watchdog failure in development");
		wd_fail_ext = 1'b0;
		vcc_ov = 1'b1;
		wait_mode(smc_pkg::SMC_FAILSAFE, 4);
		vcc_ov = 1'b0;
		wait_mode(smc_pkg::SMC_NORMAL, RD + 20);
		$display("test dev done");
	endtask
	initial begin
		nrst = 1'b0;
		soft_reset = 1'b0;
		wd_fail_ext = 1'b0;
		fault_in = '0;
		wake_in = '0;
		wd_trigger = 1'b0;
		vcc_ov = 1'b0;
		fail_out_three = 1'b1;
		int_strap = 1'b1;
		cyc(5);
		nrst = 1'b1;
		t_power();
		t_modes();
		t_faults();
		t_window();
		t_dev();
		test_done();
	end
endmodule
